//--- hdl/hold_timer.sv
`timescale 1ns/1ns
`default_nettype none

module hold_timer #(
  parameter int               WIDTH = 21,
  parameter logic [WIDTH-1:0] LIMIT = {WIDTH{1'b1}}
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  output var  logic done_o
);

  // =====================================================================
  // Hold counter
  // =====================================================================
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } timer_state_type;

  timer_state_type cur_ff;
  timer_state_type nxt_cur;

  // Counts while run is high, saturates at the limit, clears when run drops.
  always_comb begin
    nxt_cur = cur_ff;
    if (!run_i) begin
      nxt_cur.count = '0;
    end else if (cur_ff.count != LIMIT) begin
      nxt_cur.count = cur_ff.count + 1'b1;
    end
  end

  // The count clears on reset.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Done means the condition held for LIMIT consecutive cycles.
  assign done_o = (cur_ff.count == LIMIT);

endmodule

`default_nettype wire

//--- hdl/level_sync.sv
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  // =====================================================================
  // Two-stage synchroniser
  // =====================================================================
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type cur_ff;
  sync_state_type nxt_cur;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.stage1 = d_i;
    nxt_cur.stage2 = cur_ff.stage1;
  end

  // Both stages clear on reset.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign q_o = cur_ff.stage2;

endmodule

`default_nettype wire

//--- hdl/supply_protection_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "supply_seq_cfg.svh"

module supply_protection_sequencer import supply_seq_pkg::*; #(
  parameter logic        LATCH_OFF          = 1'b1,
  parameter int unsigned START_DELAY_CYCLES = `START_DELAY_CYCLES,
  parameter int unsigned GOOD_DELAY_CYCLES  = `GOOD_DELAY_CYCLES,
  parameter int unsigned LATCH_RESET_CYCLES = `LATCH_RESET_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic enable_n_i,
  input  wire logic low_supply_lockout_i,
  input  wire logic ov_high_i,
  input  wire logic ov_safe_i,
  input  wire logic oc_trip_i,
  input  wire logic hot_i,
  input  wire logic cool_i,
  input  wire logic gate_high_i,
  output var  logic switch_on_o,
  output var  logic fast_off_o,
  output var  logic soft_off_o,
  output var  logic sleep_o,
  output var  logic supply_good_n_o,
  output var  logic supply_good_n_oe_o,
  output var  logic ov_fault_o,
  output var  logic oc_fault_o,
  output var  logic hot_fault_o,
  output var  logic oc_latched_o
);

  // =====================================================================
  // Local constants
  // =====================================================================
  localparam int TW = `TIMER_WIDTH;
  localparam logic [TW-1:0] START_LIMIT = TW'(START_DELAY_CYCLES);
  localparam logic [TW-1:0] GOOD_LIMIT  = TW'(GOOD_DELAY_CYCLES);
  localparam logic [TW-1:0] LATCH_LIMIT = TW'(LATCH_RESET_CYCLES);
  localparam logic [TW-1:0] OC_LIMIT    = TW'(`OC_FILTER_CYCLES);

  // =====================================================================
  // Input synchronisation
  // =====================================================================
  logic [`SYNC_WIDTH-1:0] raw_in;
  logic [`SYNC_WIDTH-1:0] sync_in;
  logic                   en_high_s;
  logic                   lockout_s;
  logic                   ov_high_s;
  logic                   ov_safe_s;
  logic                   oc_s;
  logic                   hot_s;
  logic                   cool_s;
  logic                   gate_s;

  // Gather every asynchronous input into one bus for the synchroniser.
  // The lockout level travels inverted, as supply-ok, because the synchroniser
  // clears to zero: a cleared stage must read as lockout, or the sequencer
  // would leave lockout on the first edges after reset with the supply still low.
  assign raw_in = {enable_n_i, !low_supply_lockout_i, ov_high_i, ov_safe_i,
                   oc_trip_i, hot_i, cool_i, gate_high_i};

  // All pins pass two flip-flops before the sequencer sees them.
  level_sync #(
    .WIDTH (`SYNC_WIDTH)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (raw_in),
    .q_o    (sync_in)
  );

  // Split the synchronised bus back into named levels.
  assign en_high_s = sync_in[7];
  assign lockout_s = !sync_in[6]; // Undo the inversion at the input.
  assign ov_high_s = sync_in[5];
  assign ov_safe_s = sync_in[4];
  assign oc_s      = sync_in[3];
  assign hot_s     = sync_in[2];
  assign cool_s    = sync_in[1];
  assign gate_s    = sync_in[0];

  // =====================================================================
  // State registers
  // =====================================================================
  seq_state_type cur_ff;
  seq_state_type nxt_cur;

  // =====================================================================
  // Timers
  // =====================================================================
  logic start_run;
  logic start_done;
  logic good_run;
  logic good_done;
  logic oc_run;
  logic oc_done;
  logic latch_run;
  logic latch_done;

  // The start-up delay only runs while the input is in its safe window.
  assign start_run = (cur_ff.mode == S_DELAY) && ov_safe_s && !lockout_s && !en_high_s;

  // Power-good delay runs while switched on and the gate stays high.
  assign good_run  = (cur_ff.mode == S_ON) && gate_s;

  // Overcurrent filter needs the trip held without a break.
  assign oc_run    = (cur_ff.mode == S_ON) && oc_s;

  // Enable high must be held continuously to clear the latch.
  assign latch_run = (cur_ff.mode == S_LATCHED) && en_high_s;

  // Every delay counts cycles of the same free-running clock.
  // A timer clears the moment its condition drops, so every hold is continuous.
  // A break in the middle of a hold starts the count again from zero.
  hold_timer #(
    .WIDTH (TW),
    .LIMIT (START_LIMIT)
  ) u_start_timer (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (start_run),
    .done_o (start_done)
  );

  hold_timer #(
    .WIDTH (TW),
    .LIMIT (GOOD_LIMIT)
  ) u_good_timer (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (good_run),
    .done_o (good_done)
  );

  hold_timer #(
    .WIDTH (TW),
    .LIMIT (OC_LIMIT)
  ) u_oc_timer (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (oc_run),
    .done_o (oc_done)
  );

  hold_timer #(
    .WIDTH (TW),
    .LIMIT (LATCH_LIMIT)
  ) u_latch_timer (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (latch_run),
    .done_o (latch_done)
  );

  // =====================================================================
  // Sequencer next state
  // =====================================================================
  // Lockout dominates, then sleep, then heat, overvoltage and overcurrent.
  // The overvoltage and overcurrent flags stay set through the off states and clear only when the next
  // start-up delay completes, so the cause of the last opening stays visible.
  always_comb begin
    nxt_cur = cur_ff;
    if (lockout_s) begin
      nxt_cur.mode    = S_LOCKOUT;
      nxt_cur.latched = 1'b0;
    end else begin
      case (cur_ff.mode)
        S_LOCKOUT: begin
          if (en_high_s) begin
            nxt_cur.mode = S_SLEEP;
          end else begin
            nxt_cur.mode = S_DELAY;
          end
        end
        S_SLEEP: begin
          if (!en_high_s) begin
            nxt_cur.mode = S_DELAY;
          end
        end
        S_DELAY: begin
          if (en_high_s) begin
            nxt_cur.mode = S_SLEEP;
          end else if (hot_s) begin
            nxt_cur.mode = S_THERMAL;
          end else if (start_done) begin
            nxt_cur.mode     = S_ON;
            nxt_cur.ov_fault = 1'b0;
            nxt_cur.oc_fault = 1'b0;
          end
        end
        S_ON: begin
          if (en_high_s) begin
            nxt_cur.mode = S_SLEEP;
          end else if (hot_s) begin
            nxt_cur.mode = S_THERMAL;
          end else if (ov_high_s) begin
            nxt_cur.mode     = S_DELAY;
            nxt_cur.ov_fault = 1'b1;
          end else if (oc_done) begin
            nxt_cur.oc_fault = 1'b1;
            if (LATCH_OFF) begin
              nxt_cur.mode    = S_LATCHED;
              nxt_cur.latched = 1'b1;
            end else begin
              nxt_cur.mode = S_DELAY;
            end
          end
        end
        S_THERMAL: begin
          if (en_high_s) begin
            nxt_cur.mode = S_SLEEP;
          end else if (cool_s && !hot_s) begin
            nxt_cur.mode = S_DELAY;
          end
        end
        S_LATCHED: begin
          if (latch_done) begin
            nxt_cur.mode    = S_SLEEP;
            nxt_cur.latched = 1'b0;
          end
        end
        default: begin
          nxt_cur.mode = S_LOCKOUT;
        end
      endcase
    end

    // Output drives follow the state being entered.
    // Sleep uses the weak pull-down alone, which softens the input transient.
    nxt_cur.hot_fault = (nxt_cur.mode == S_THERMAL);
    nxt_cur.switch_on = (nxt_cur.mode == S_ON);
    nxt_cur.sleep     = (nxt_cur.mode == S_SLEEP);
    nxt_cur.soft_off  = (nxt_cur.mode == S_SLEEP);
    nxt_cur.fast_off  = (nxt_cur.mode != S_ON) && (nxt_cur.mode != S_SLEEP);

    // The open-drain pull-down only engages in the on state after the delay.
    nxt_cur.good_out  = `GOOD_OUT_RESET;
    nxt_cur.good_oe   = (nxt_cur.mode == S_ON) && (cur_ff.mode == S_ON)
                        && good_done && gate_s;
  end

  // =====================================================================
  // Registers
  // =====================================================================
  // Synchronous active-low reset puts the sequencer into lockout.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur_ff           <= '0;
      cur_ff.mode      <= S_LOCKOUT;
      cur_ff.fast_off  <= 1'b1;
      cur_ff.good_out  <= `GOOD_OUT_RESET;
      cur_ff.good_oe   <= `GOOD_OE_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  // Every output is a field of the registered state.
  assign switch_on_o        = cur_ff.switch_on;
  assign fast_off_o         = cur_ff.fast_off;
  assign soft_off_o         = cur_ff.soft_off;
  assign sleep_o            = cur_ff.sleep;
  assign supply_good_n_o    = cur_ff.good_out;
  assign supply_good_n_oe_o = cur_ff.good_oe;
  assign ov_fault_o         = cur_ff.ov_fault;
  assign oc_fault_o         = cur_ff.oc_fault;
  assign hot_fault_o        = cur_ff.hot_fault;
  assign oc_latched_o       = cur_ff.latched;

endmodule

`default_nettype wire

//--- hdl/supply_seq_cfg.svh
`ifndef SUPPLY_SEQ_CFG_SVH
`define SUPPLY_SEQ_CFG_SVH

// =====================================================================
// Clock
// =====================================================================
`define CLK_PERIOD_NS      100

// =====================================================================
// Times as printed, in nanoseconds
// =====================================================================
`define START_DELAY_NS     130000000
`define GOOD_DELAY_NS      65000000
`define OC_FILTER_NS       10000
`define LATCH_RESET_NS     500000
`define OV_OFF_MAX_NS      1000

// =====================================================================
// Cycle counts derived from the times
// =====================================================================
// Least times round up; the "more than" times add one cycle.
`define START_DELAY_CYCLES ((`START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GOOD_DELAY_CYCLES  (`GOOD_DELAY_NS / `CLK_PERIOD_NS + 1)
`define OC_FILTER_CYCLES   (`OC_FILTER_NS / `CLK_PERIOD_NS + 1)
`define LATCH_RESET_CYCLES (`LATCH_RESET_NS / `CLK_PERIOD_NS + 1)
`define OV_OFF_MAX_CYCLES  (`OV_OFF_MAX_NS / `CLK_PERIOD_NS)

// =====================================================================
// Widths and reset values
// =====================================================================
`define TIMER_WIDTH        21
`define SYNC_WIDTH         8
`define GOOD_OUT_RESET     1'b0
`define GOOD_OE_RESET      1'b0

`endif

//--- hdl/supply_seq_pkg.sv
package supply_seq_pkg;

  // =====================================================================
  // Sequencer states
  // =====================================================================
  typedef enum logic [2:0] {
    S_LOCKOUT,
    S_SLEEP,
    S_DELAY,
    S_ON,
    S_THERMAL,
    S_LATCHED
  } seq_mode_type;

  // =====================================================================
  // Complete state of the sequencer
  // =====================================================================
  typedef struct packed {
    seq_mode_type mode;
    logic         switch_on;
    logic         fast_off;
    logic         soft_off;
    logic         sleep;
    logic         good_out;
    logic         good_oe;
    logic         ov_fault;
    logic         oc_fault;
    logic         hot_fault;
    logic         latched;
  } seq_state_type;

endpackage

//--- testbench/supply_load_model.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// Pass switch gate and load seen by the sequencer
// =====================================================================
module supply_load_model #(
  parameter int RAMP_CYCLES = 4
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic switch_on_i,
  input  wire logic short_i,
  input  wire logic sag_i,
  output var  logic gate_high_o,
  output var  logic oc_trip_o
);
  int ramp = 0;

  // The gate climbs while driven on, collapses when pulled off or sagging.
  always @(posedge clk_i) begin
    ramp <= (!nrst_i || !switch_on_i) ? 0 : ramp + ((ramp < 1000) ? 1 : 0);
    gate_high_o <= nrst_i && switch_on_i && !sag_i && ramp >= RAMP_CYCLES;
    oc_trip_o <= nrst_i && switch_on_i && short_i; // A shorted load only draws current through the switch.
  end
endmodule

`default_nettype wire

//--- testbench/supply_protection_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %0h want %0h", $time, g, e); end end

// =====================================================================
// Self-checking bench for the supply sequencer
// =====================================================================
module supply_protection_sequencer_tb;
  localparam int START = 20;
  localparam int GOOD  = 10;
  localparam int HOLD  = 8;
  logic clk = 1'b0, nrst = 1'b0, en_n = 1'b0, lockout = 1'b1, ov_high = 1'b0, ov_safe = 1'b1;
  logic hot = 1'b0, cool = 1'b1, short_load = 1'b0, sag = 1'b0;
  logic gate_high, oc_trip, switch_on, fast_off, soft_off, sleep, good_n, good_oe;
  logic ov_fault, oc_fault, hot_fault, latched;
  logic r_gate_high, r_oc_trip, r_switch_on, r_oc_fault, r_latched;
  int bad_count = 0, checks = 0, cycles = 0, n;

  supply_protection_sequencer #(
    .LATCH_OFF(1'b1), .START_DELAY_CYCLES(START), .GOOD_DELAY_CYCLES(GOOD), .LATCH_RESET_CYCLES(HOLD)
  ) dut (
    .clk_i(clk), .nrst_i(nrst), .enable_n_i(en_n), .low_supply_lockout_i(lockout), .ov_high_i(ov_high),
    .ov_safe_i(ov_safe), .oc_trip_i(oc_trip), .hot_i(hot), .cool_i(cool), .gate_high_i(gate_high),
    .switch_on_o(switch_on), .fast_off_o(fast_off), .soft_off_o(soft_off), .sleep_o(sleep),
    .supply_good_n_o(good_n), .supply_good_n_oe_o(good_oe), .ov_fault_o(ov_fault),
    .oc_fault_o(oc_fault), .hot_fault_o(hot_fault), .oc_latched_o(latched)
  );

  supply_load_model load (
    .clk_i(clk), .nrst_i(nrst), .switch_on_i(switch_on), .short_i(short_load), .sag_i(sag),
    .gate_high_o(gate_high), .oc_trip_o(oc_trip)
  );

  // Auto-retry variant shares every pin but has its own load.
  supply_protection_sequencer #(
    .LATCH_OFF(1'b0), .START_DELAY_CYCLES(START), .GOOD_DELAY_CYCLES(GOOD), .LATCH_RESET_CYCLES(HOLD)
  ) dut_retry (
    .clk_i(clk), .nrst_i(nrst), .enable_n_i(en_n), .low_supply_lockout_i(lockout), .ov_high_i(ov_high),
    .ov_safe_i(ov_safe), .oc_trip_i(r_oc_trip), .hot_i(hot), .cool_i(cool), .gate_high_i(r_gate_high),
    .switch_on_o(r_switch_on), .fast_off_o(), .soft_off_o(), .sleep_o(),
    .supply_good_n_o(), .supply_good_n_oe_o(), .ov_fault_o(),
    .oc_fault_o(r_oc_fault), .hot_fault_o(), .oc_latched_o(r_latched)
  );

  supply_load_model load_retry (
    .clk_i(clk), .nrst_i(nrst), .switch_on_i(r_switch_on), .short_i(short_load), .sag_i(sag),
    .gate_high_o(r_gate_high), .oc_trip_o(r_oc_trip)
  );

  // Clock at 10 MHz.
  always #50 clk = ~clk;

  // A hung run is cut short and counted as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Counts cycles until the level of sig reaches want, with a bound.
  task automatic wait_for(ref logic sig, input logic want, output int k);
    k = 0;
    while (sig !== want && k < 200) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic t_startup;
    cyc(6);
    `CHECK({switch_on, good_oe}, 2'b00)
    @(posedge clk) lockout <= 1'b0;
    wait_for(switch_on, 1'b1, n);
    `CHECK(n >= START && n <= START + 8, 1'b1)
    `CHECK(good_oe, 1'b0)
    wait_for(good_oe, 1'b1, n);
    `CHECK(n >= GOOD && n <= GOOD + 12, 1'b1)
    `CHECK(good_n, 1'b0)
    @(posedge clk) sag <= 1'b1;
    cyc(5);
    `CHECK(good_oe, 1'b0)
    @(posedge clk) sag <= 1'b0;
    wait_for(good_oe, 1'b1, n);
    $display("test startup done");
  endtask

  task automatic t_overvoltage;
    @(posedge clk) {ov_high, ov_safe} <= 2'b10;
    wait_for(switch_on, 1'b0, n);
    `CHECK(n <= 10, 1'b1)
    `CHECK({fast_off, ov_fault, good_oe}, 3'b110)
    @(posedge clk) ov_high <= 1'b0;
    cyc(40);
    `CHECK(switch_on, 1'b0)
    @(posedge clk) ov_safe <= 1'b1;
    cyc(10);
    @(posedge clk) ov_safe <= 1'b0;
    cyc(5);
    @(posedge clk) ov_safe <= 1'b1;
    wait_for(switch_on, 1'b1, n);
    `CHECK(n >= START && n <= START + 8, 1'b1)
    wait_for(good_oe, 1'b1, n);
    $display("test overvoltage done");
  endtask

  task automatic t_overcurrent;
    @(posedge clk) short_load <= 1'b1;
    cyc(50);
    @(posedge clk) short_load <= 1'b0;
    cyc(5);
    `CHECK({oc_fault, switch_on}, 2'b01)
    @(posedge clk) short_load <= 1'b1;
    wait_for(oc_fault, 1'b1, n);
    `CHECK(n >= 101 && n <= 112, 1'b1)
    `CHECK({switch_on, good_oe, latched}, 3'b001)
    `CHECK({r_switch_on, r_oc_fault, r_latched}, 3'b010)
    @(posedge clk) short_load <= 1'b0;
    cyc(40);
    `CHECK(switch_on, 1'b0)
    `CHECK({r_switch_on, r_latched}, 2'b10)
    @(posedge clk) en_n <= 1'b1;
    cyc(4);
    @(posedge clk) en_n <= 1'b0;
    cyc(30);
    `CHECK({latched, switch_on}, 2'b10)
    @(posedge clk) en_n <= 1'b1;
    cyc(HOLD + 12);
    `CHECK({sleep, soft_off, latched, switch_on}, 4'b1100)
    @(posedge clk) en_n <= 1'b0;
    wait_for(switch_on, 1'b1, n);
    `CHECK(n >= START && n <= START + 8, 1'b1)
    wait_for(good_oe, 1'b1, n);
    $display("test overcurrent done");
  endtask

  task automatic t_thermal;
    @(posedge clk) {hot, cool} <= 2'b10;
    cyc(5);
    `CHECK({switch_on, hot_fault, good_oe}, 3'b010)
    @(posedge clk) hot <= 1'b0;
    cyc(30);
    `CHECK(switch_on, 1'b0)
    @(posedge clk) cool <= 1'b1;
    wait_for(switch_on, 1'b1, n);
    `CHECK(n >= START && n <= START + 8, 1'b1)
    $display("test thermal done");
  endtask

  task automatic t_lockout;
    @(posedge clk) short_load <= 1'b1;
    wait_for(latched, 1'b1, n);
    `CHECK(switch_on, 1'b0)
    @(posedge clk) lockout <= 1'b1;
    cyc(5);
    `CHECK({latched, switch_on, good_oe}, 3'b000)
    @(posedge clk) {lockout, short_load} <= 2'b00;
    wait_for(switch_on, 1'b1, n);
    `CHECK(n >= START && n <= START + 8, 1'b1)
    $display("test lockout done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset for eight cycles, then run every scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_startup();
    t_overvoltage();
    t_overcurrent();
    t_thermal();
    t_lockout();
    conclude();
  end
endmodule

`default_nettype wire

//--- testbench/supply_seq_assertions.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// Port checker for the supply sequencer
// =====================================================================
module supply_seq_assertions #(
  parameter int unsigned START_DELAY_CYCLES = 20,
  parameter int unsigned GOOD_DELAY_CYCLES  = 10
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_n_i,
  input wire logic low_supply_lockout_i,
  input wire logic ov_high_i,
  input wire logic ov_safe_i,
  input wire logic oc_trip_i,
  input wire logic hot_i,
  input wire logic gate_high_i,
  input wire logic switch_on_o,
  input wire logic soft_off_o,
  input wire logic sleep_o,
  input wire logic supply_good_n_oe_o,
  input wire logic oc_fault_o,
  input wire logic oc_latched_o
);
  int off_cnt;
  int gate_cnt;
  int oc_cnt;
  int safe_cnt;
  int on_gate_cnt;

  // Run lengths of watched levels give the time references below.
  always_ff @(posedge clk_i) begin
    off_cnt     <= (!nrst_i || switch_on_o) ? 0 : off_cnt + 1;
    gate_cnt    <= (!nrst_i || !gate_high_i) ? 0 : gate_cnt + 1;
    oc_cnt      <= (!nrst_i || !oc_trip_i) ? 0 : oc_cnt + 1;
    safe_cnt    <= (!nrst_i || !ov_safe_i) ? 0 : safe_cnt + 1;
    on_gate_cnt <= (!nrst_i || !(gate_high_i && switch_on_o)) ? 0 : on_gate_cnt + 1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_lockout_off: assert property (low_supply_lockout_i [*4] |-> !switch_on_o && !supply_good_n_oe_o)
    else $error("switch or power-good active in lockout");
  a_ov_fast_off: assert property (ov_high_i && switch_on_o |-> ##[1:10] !switch_on_o)
    else $error("switch still on after overvoltage");
  a_start_wait: assert property ($rose(switch_on_o) |-> off_cnt >= START_DELAY_CYCLES &&
    $past(safe_cnt, 2) + 2 >= START_DELAY_CYCLES) else $error("switch on before the delay ran");
  a_good_after_gate: assert property ($rose(supply_good_n_oe_o) |-> gate_cnt >= GOOD_DELAY_CYCLES)
    else $error("power-good asserted too early");
  a_good_arrives: assert property (on_gate_cnt == GOOD_DELAY_CYCLES + 5 |-> supply_good_n_oe_o)
    else $error("power-good missing after gate delay");
  a_gate_low_release: assert property (!gate_high_i [*4] |-> !supply_good_n_oe_o)
    else $error("power-good held with gate low");
  a_good_needs_on: assert property (!switch_on_o |-> !supply_good_n_oe_o)
    else $error("power-good asserted with switch off");
  a_oc_filtered: assert property ($rose(oc_fault_o) |-> $past(oc_cnt, 2) >= 100 &&
    !switch_on_o && !supply_good_n_oe_o) else $error("overcurrent fault wrong");
  a_latch_holds: assert property (oc_latched_o |-> !switch_on_o)
    else $error("switch on while latched");
  a_sleep_state: assert property ((enable_n_i && !low_supply_lockout_i) [*4] |-> !switch_on_o &&
    (oc_latched_o || (sleep_o && soft_off_o))) else $error("sleep not entered");
  a_hot_off: assert property ((hot_i && !low_supply_lockout_i && !enable_n_i) [*4] |->
    !switch_on_o && !supply_good_n_oe_o) else $error("switch on while hot");

  c_good: cover property ($rose(supply_good_n_oe_o));
  c_latch: cover property ($rose(oc_latched_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule

bind supply_protection_sequencer supply_seq_assertions #(
  .START_DELAY_CYCLES(START_DELAY_CYCLES), .GOOD_DELAY_CYCLES(GOOD_DELAY_CYCLES)
) chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .enable_n_i(enable_n_i), .low_supply_lockout_i(low_supply_lockout_i),
  .ov_high_i(ov_high_i), .ov_safe_i(ov_safe_i), .oc_trip_i(oc_trip_i), .hot_i(hot_i),
  .gate_high_i(gate_high_i), .switch_on_o(switch_on_o), .soft_off_o(soft_off_o), .sleep_o(sleep_o),
  .supply_good_n_oe_o(supply_good_n_oe_o), .oc_fault_o(oc_fault_o), .oc_latched_o(oc_latched_o)
);

`default_nettype wire
